// ---- inc/ldiw_defs.svh ----
// constants for the led driver two-wire write port: bus codes, sub-addresses, timing
// assumes it is included by bare name from every file that needs a figure
`ifndef LDIW_DEFS_SVH
`define LDIW_DEFS_SVH

// ==========================================================
// serial frame
`define LDIW_TARGET_ADDR 7'h1B
`define LDIW_RW_WRITE 1'h0
`define LDIW_BYTE_W 8
`define LDIW_BIT_LAST 3'h7
`define LDIW_BUS_IDLE 1'h1
`define LDIW_SDA_LOW 1'h0

// ==========================================================
// sub-address decode, low three bits only
`define LDIW_SUB_W 3
`define LDIW_SUB_NONE 3'h0
`define LDIW_SUB_RED_GREEN 3'h1
`define LDIW_SUB_BLUE_AUX 3'h2
`define LDIW_SUB_MAIN 3'h3
`define LDIW_SUB_SECONDARY 3'h4
`define LDIW_SUB_AUX_SELECT 3'h5
`define LDIW_SUB_CAMERA 3'h6
`define LDIW_SUB_OPTIONS 3'h7

// ==========================================================
// aux output source codes
`define LDIW_AUXSEL_AUX 2'h0
`define LDIW_AUXSEL_MAIN 2'h1
`define LDIW_AUXSEL_SUB 2'h2
`define LDIW_AUXSEL_CAM 2'h3
`define LDIW_AUX_COUNT 4

// ==========================================================
// dropout inputs: bits 0..3 are red, green, blue, aux4
`define LDIW_DROP_W 10
`define LDIW_DROP_COLOR_MASK 10'h00F

// ==========================================================
// timing
`define LDIW_CLK_MHZ 20
`define LDIW_DROP_DELAY_US 400
`define LDIW_GLITCH_CYCLES 2

`endif

// ---- inc/ldiw_pkg.sv ----
// types shared by the led driver write port files
// assumes ldiw_defs.svh is on the include path
`include "ldiw_defs.svh"

package ldiw_pkg;

    // ==========================================================
    // register layouts
    typedef struct packed {
        logic pump_double_hold;
        logic pump_one_half_hold;
        logic test_hook_two;
        logic test_hook_one;
        logic color_dropout_mask;
        logic flash_level_lock;
        logic gate_pin_target;
        logic not_used;
    } ldiw_opt_t;

    typedef struct packed {
        logic [3:0] hi;
        logic [3:0] lo;
    } ldiw_nibbles_t;

    typedef logic [`LDIW_AUX_COUNT-1:0][1:0] ldiw_auxsel_t;

    typedef struct packed {
        ldiw_opt_t options_control;
        ldiw_nibbles_t camera_high_low_level;
        ldiw_auxsel_t aux_source_select;
        logic [7:0] secondary_display_level;
        logic [7:0] main_display_level;
        ldiw_nibbles_t blue_aux_level;
        ldiw_nibbles_t red_green_level;
    } ldiw_regs_t;

    // ==========================================================
    // dac drive and modes
    typedef struct packed {
        logic [3:0] red;
        logic [3:0] green;
        logic [3:0] blue;
        logic [7:0] main;
        logic [7:0] secondary;
        logic [3:0] camera;
    } ldiw_dac_t;

    typedef enum logic [1:0] {PUMP_ONE, PUMP_ONE_HALF, PUMP_DOUBLE} ldiw_pump_t;

    typedef enum logic [2:0] {
        ST_IDLE, ST_ADDR, ST_ADDR_ACK, ST_SUB, ST_SUB_ACK, ST_DATA, ST_DATA_ACK, ST_IGNORE
    } ldiw_state_t;

endpackage : ldiw_pkg

// ---- hw/ldiw_pin_filter.sv ----
// one bus line: two-flop synchroniser followed by a stability filter
// assumes the pin is asynchronous to sys_clk and idles at IDLE_LEVEL
`timescale 1ns/1ps
`include "ldiw_defs.svh"

module ldiw_pin_filter import ldiw_pkg::*; #(
    parameter int STABLE_CYCLES = `LDIW_GLITCH_CYCLES,
    parameter logic IDLE_LEVEL = `LDIW_BUS_IDLE
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic pin_async,
    output logic level_reg
);
    localparam int CW = $clog2(STABLE_CYCLES + 1);

    logic sync1_reg;
    logic sync2_reg;
    logic [CW-1:0] stable_cnt_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sync1_reg <= IDLE_LEVEL;
            sync2_reg <= IDLE_LEVEL;
        end else begin
            sync1_reg <= pin_async;
            sync2_reg <= sync1_reg;
        end
    end

    // a new level must persist STABLE_CYCLES samples, so short spikes never reach the decoder
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            level_reg <= IDLE_LEVEL;
            stable_cnt_reg <= '0;
        end else if (sync2_reg == level_reg) begin
            stable_cnt_reg <= '0;
        end else if (stable_cnt_reg == CW'(STABLE_CYCLES - 1)) begin
            level_reg <= sync2_reg;
            stable_cnt_reg <= '0;
        end else begin
            stable_cnt_reg <= stable_cnt_reg + 1'b1;
        end
    end

endmodule : ldiw_pin_filter

// ---- hw/ldiw_pump_mode.sv ----
// charge pump mode selection: qualified dropout steps up, update pulse returns to unity
// assumes dropout is already synchronised and masked by the caller
`timescale 1ns/1ps
`include "ldiw_defs.svh"

module ldiw_pump_mode import ldiw_pkg::*; #(
    parameter int DROP_CYCLES = `LDIW_DROP_DELAY_US * `LDIW_CLK_MHZ
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic dropout,
    input wire logic back_to_one,
    input wire logic one_half_hold,
    input wire logic double_hold,
    output ldiw_pump_t mode_reg
);
    localparam int CW = $clog2(DROP_CYCLES + 1);

    ldiw_pump_t state_reg;
    logic [CW-1:0] qual_cnt_reg;
    logic step;

    assign step = dropout && (qual_cnt_reg == CW'(DROP_CYCLES - 1));

    // dropout must stay present for the whole delay; each further step needs a fresh delay
    always_ff @(posedge sys_clk) begin
        if (!rst_n || back_to_one || !dropout || step) begin
            qual_cnt_reg <= '0;
        end else begin
            qual_cnt_reg <= qual_cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= PUMP_ONE;
        end else if (back_to_one) begin
            state_reg <= PUMP_ONE;
        end else if (step) begin
            unique case (state_reg)
                PUMP_ONE: state_reg <= PUMP_ONE_HALF;
                PUMP_ONE_HALF: state_reg <= PUMP_DOUBLE;
                PUMP_DOUBLE: state_reg <= PUMP_DOUBLE;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            mode_reg <= PUMP_ONE;
        end else if (double_hold) begin
            mode_reg <= PUMP_DOUBLE;
        end else if (one_half_hold) begin
            mode_reg <= PUMP_ONE_HALF;
        end else begin
            mode_reg <= state_reg;
        end
    end

endmodule : ldiw_pump_mode

// ---- hw/ldiw_top.sv ----
// led driver write-only two-wire target port, holding and active registers, pump mode
// assumes bus lines and control pins are asynchronous and resolved by the bench from sda_oe_n
//
// What this block does
// - dropout steps pump one to half to double
// - dropout must persist about 400 us first
// - register update or flash pin fall resets unity
// - target only, never drives read data
// - write: start, address, sub-address, data, stop
// - decode low three sub-address bits, zero none
// - sub-address one: green high, red low
// - sub-address two: aux high, blue low
// - sub-address three: main brightness eight bits
// - sub-address four: secondary brightness eight bits
// - sub-address five: two-bit source per aux output
// - sub-address six: camera high and low nibbles
// - options bit one: gate pin targets secondary
// - options bit two: camera high, pin ignored
// - options bit three: mask colour and aux4 dropout
// - options bit six holds pump at half
// - options bit seven holds double, overrides six
// - up to 400 kHz, glitch filtered lines
// - start and stop by data edge, clock high
// - eight bits msb first, then acknowledge clock
// - answer only address 0011011 with write bit
// - data byte latched when acknowledge returned
// - valid write then stop loads all registers
// - flash pin low picks low nibble, high high
`timescale 1ns/1ps
`include "ldiw_defs.svh"

module ldiw_top import ldiw_pkg::*; #(
    parameter int DROP_CYCLES = `LDIW_DROP_DELAY_US * `LDIW_CLK_MHZ,
    parameter int GLITCH_CYCLES = `LDIW_GLITCH_CYCLES
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin,
    output logic sda_out,
    output logic sda_oe_n,
    input wire logic flash_level_pin,
    input wire logic display_gate_pin,
    input wire logic [`LDIW_DROP_W-1:0] dropout_pin,
    output ldiw_dac_t dac_level,
    output logic [`LDIW_AUX_COUNT-1:0][7:0] aux_drive,
    output ldiw_pump_t pump_mode,
    output logic load_pulse
);
    localparam int CTRL_W = `LDIW_DROP_W + 2;

    // ==========================================================
    // bus line conditioning
    logic [1:0] bus_raw;
    logic [1:0] bus_flt;
    logic scl;
    logic sda;

    assign bus_raw = {scl_pin, sda_pin};

    // filters start at the idle level so a released bus at reset shows no edge
    for (genvar i = 0; i < 2; i++) begin : g_bus_filter
        ldiw_pin_filter #(
            .STABLE_CYCLES(GLITCH_CYCLES),
            .IDLE_LEVEL(`LDIW_BUS_IDLE)
        ) u_filter (
            .sys_clk(sys_clk),
            .rst_n(rst_n),
            .pin_async(bus_raw[i]),
            .level_reg(bus_flt[i])
        );
    end

    assign scl = bus_flt[1];
    assign sda = bus_flt[0];

    // ==========================================================
    // control pin synchronisers
    logic [CTRL_W-1:0] ctrl_raw;
    logic [CTRL_W-1:0] ctrl_s1_reg;
    logic [CTRL_W-1:0] ctrl_s2_reg;
    logic flash_sync;
    logic gate_sync;
    logic [`LDIW_DROP_W-1:0] drop_sync;

    assign ctrl_raw = {flash_level_pin, display_gate_pin, dropout_pin};

    for (genvar i = 0; i < CTRL_W; i++) begin : g_ctrl_sync
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                ctrl_s1_reg[i] <= '0;
                ctrl_s2_reg[i] <= '0;
            end else begin
                ctrl_s1_reg[i] <= ctrl_raw[i];
                ctrl_s2_reg[i] <= ctrl_s1_reg[i];
            end
        end
    end

    assign {flash_sync, gate_sync, drop_sync} = ctrl_s2_reg;

    // ==========================================================
    // bus edge and condition detection
    logic scl_d_reg;
    logic sda_d_reg;
    logic flash_d_reg;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic flash_fall;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            scl_d_reg <= `LDIW_BUS_IDLE;
            sda_d_reg <= `LDIW_BUS_IDLE;
            flash_d_reg <= '0;
        end else begin
            scl_d_reg <= scl;
            sda_d_reg <= sda;
            flash_d_reg <= flash_sync;
        end
    end

    assign scl_rise = scl && !scl_d_reg;
    assign scl_fall = !scl && scl_d_reg;
    assign bus_start = scl && scl_d_reg && sda_d_reg && !sda;
    assign bus_stop = scl && scl_d_reg && !sda_d_reg && sda;
    assign flash_fall = flash_d_reg && !flash_sync;

    // ==========================================================
    // byte shifter
    ldiw_state_t state_reg;
    logic [`LDIW_BYTE_W-1:0] shift_reg;
    logic [2:0] bit_cnt_reg;
    logic byte_full_reg;
    logic receiving;

    assign receiving = (state_reg == ST_ADDR) || (state_reg == ST_SUB) ||
                       (state_reg == ST_DATA);

    // ack clocks are not counted, so the counter is back at zero for the next byte
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            shift_reg <= '0;
            bit_cnt_reg <= '0;
            byte_full_reg <= '0;
        end else if (bus_start || bus_stop) begin
            bit_cnt_reg <= '0;
            byte_full_reg <= '0;
        end else if (receiving && scl_rise && !byte_full_reg) begin
            shift_reg <= {shift_reg[`LDIW_BYTE_W-2:0], sda};
            bit_cnt_reg <= bit_cnt_reg + 1'b1;
            byte_full_reg <= (bit_cnt_reg == `LDIW_BIT_LAST);
        end else if (scl_fall) begin
            byte_full_reg <= '0;
        end
    end

    // ==========================================================
    // frame sequencer
    logic byte_end;
    logic addr_match;
    logic addr_ack_go;
    logic data_take;

    assign byte_end = scl_fall && byte_full_reg;
    assign addr_match = (shift_reg == {`LDIW_TARGET_ADDR, `LDIW_RW_WRITE});
    assign addr_ack_go = (state_reg == ST_ADDR) && byte_end && addr_match;
    assign data_take = (state_reg == ST_DATA) && byte_end;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            state_reg <= ST_IDLE;
            sda_oe_n <= `LDIW_BUS_IDLE;
        end else if (bus_start) begin
            state_reg <= ST_ADDR;
            sda_oe_n <= `LDIW_BUS_IDLE;
        end else if (bus_stop) begin
            state_reg <= ST_IDLE;
            sda_oe_n <= `LDIW_BUS_IDLE;
        end else begin
            unique case (state_reg)
                ST_IDLE, ST_IGNORE: begin
                    sda_oe_n <= `LDIW_BUS_IDLE;
                end
                ST_ADDR: begin
                    if (byte_end) begin
                        // wrong address or read bit: stay silent until the next start
                        state_reg <= addr_match ? ST_ADDR_ACK : ST_IGNORE;
                        sda_oe_n <= !addr_match;
                    end
                end
                ST_SUB: begin
                    if (byte_end) begin
                        state_reg <= ST_SUB_ACK;
                        sda_oe_n <= '0;
                    end
                end
                ST_DATA: begin
                    if (byte_end) begin
                        state_reg <= ST_DATA_ACK;
                        sda_oe_n <= '0;
                    end
                end
                ST_ADDR_ACK: begin
                    if (scl_fall) begin
                        state_reg <= ST_SUB;
                        sda_oe_n <= `LDIW_BUS_IDLE;
                    end
                end
                ST_SUB_ACK: begin
                    if (scl_fall) begin
                        state_reg <= ST_DATA;
                        sda_oe_n <= `LDIW_BUS_IDLE;
                    end
                end
                ST_DATA_ACK: begin
                    // further sub-address and data pairs may follow before the stop
                    if (scl_fall) begin
                        state_reg <= ST_SUB;
                        sda_oe_n <= `LDIW_BUS_IDLE;
                    end
                end
            endcase
        end
    end

    // the line is only ever pulled low for acknowledge; no read data path exists
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sda_out <= `LDIW_SDA_LOW;
        end else begin
            sda_out <= `LDIW_SDA_LOW;
        end
    end

    // ==========================================================
    // sub-address and holding latches
    logic [`LDIW_SUB_W-1:0] sub_sel_reg;
    ldiw_regs_t hold_reg;
    ldiw_regs_t active_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            sub_sel_reg <= `LDIW_SUB_NONE;
        end else if ((state_reg == ST_SUB) && byte_end) begin
            sub_sel_reg <= shift_reg[`LDIW_SUB_W-1:0];
        end
    end

    // shared registers take all eight bits at once since one acknowledge writes them
    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            hold_reg <= '0;
        end else if (data_take) begin
            unique case (sub_sel_reg)
                `LDIW_SUB_NONE: ;
                `LDIW_SUB_RED_GREEN: hold_reg.red_green_level <= shift_reg;
                `LDIW_SUB_BLUE_AUX: hold_reg.blue_aux_level <= shift_reg;
                `LDIW_SUB_MAIN: hold_reg.main_display_level <= shift_reg;
                `LDIW_SUB_SECONDARY: hold_reg.secondary_display_level <= shift_reg;
                `LDIW_SUB_AUX_SELECT: hold_reg.aux_source_select <= shift_reg;
                `LDIW_SUB_CAMERA: hold_reg.camera_high_low_level <= shift_reg;
                // test hook bits are stored as written; the host keeps them at zero
                `LDIW_SUB_OPTIONS: hold_reg.options_control <= shift_reg;
            endcase
        end
    end

    // ==========================================================
    // stop handling and load
    logic pending_reg;
    logic incomplete_reg;
    logic load_go;

    // a stop inside our own unfinished frame is ignored, keeping the last complete data
    assign load_go = bus_stop && pending_reg && !incomplete_reg;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            incomplete_reg <= '0;
        end else if (addr_ack_go) begin
            incomplete_reg <= '1;
        end else if (data_take) begin
            incomplete_reg <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            pending_reg <= '0;
        end else if (data_take) begin
            pending_reg <= '1;
        end else if (load_go) begin
            pending_reg <= '0;
        end
    end

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            active_reg <= '0;
            load_pulse <= '0;
        end else begin
            load_pulse <= load_go;
            if (load_go) begin
                active_reg <= hold_reg;
            end
        end
    end

    // ==========================================================
    // dac drive
    ldiw_opt_t opts;
    logic rgb_on;
    logic sub_on;
    logic cam_high_sel;

    assign opts = active_reg.options_control;
    assign rgb_on = opts.gate_pin_target || gate_sync;
    assign sub_on = !opts.gate_pin_target || gate_sync;
    assign cam_high_sel = opts.flash_level_lock || flash_sync;

    always_ff @(posedge sys_clk) begin
        if (!rst_n) begin
            dac_level <= '0;
        end else begin
            dac_level.red <= rgb_on ? active_reg.red_green_level.lo : '0;
            dac_level.green <= rgb_on ? active_reg.red_green_level.hi : '0;
            dac_level.blue <= rgb_on ? active_reg.blue_aux_level.lo : '0;
            dac_level.main <= active_reg.main_display_level;
            dac_level.secondary <= sub_on ? active_reg.secondary_display_level : '0;
            dac_level.camera <= cam_high_sel ? active_reg.camera_high_low_level.hi :
                                               active_reg.camera_high_low_level.lo;
        end
    end

    // aux outputs set to camera follow the camera nibble picked by the flash pin or the flash level lock bit
    for (genvar i = 0; i < `LDIW_AUX_COUNT; i++) begin : g_aux_mux
        always_ff @(posedge sys_clk) begin
            if (!rst_n) begin
                aux_drive[i] <= '0;
            end else begin
                unique case (active_reg.aux_source_select[i])
                    `LDIW_AUXSEL_AUX: aux_drive[i] <= 8'(active_reg.blue_aux_level.hi);
                    `LDIW_AUXSEL_MAIN: aux_drive[i] <= active_reg.main_display_level;
                    `LDIW_AUXSEL_SUB: aux_drive[i] <= active_reg.secondary_display_level;
                    `LDIW_AUXSEL_CAM: aux_drive[i] <= 8'(cam_high_sel ?
                        active_reg.camera_high_low_level.hi :
                        active_reg.camera_high_low_level.lo);
                endcase
            end
        end
    end

    // ==========================================================
    // charge pump mode
    logic [`LDIW_DROP_W-1:0] drop_used;
    logic back_to_one;

    assign drop_used = drop_sync &
        ~(opts.color_dropout_mask ? `LDIW_DROP_COLOR_MASK : '0);
    assign back_to_one = load_pulse || flash_fall;

    ldiw_pump_mode #(
        .DROP_CYCLES(DROP_CYCLES)
    ) u_pump (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .dropout(|drop_used),
        .back_to_one(back_to_one),
        .one_half_hold(opts.pump_one_half_hold),
        .double_hold(opts.pump_double_hold),
        .mode_reg(pump_mode)
    );

endmodule : ldiw_top

// ---- tb/ldiw_monitor.sv ----
// checker for the led driver write port, top ports only
// assumes it is bound to ldiw_top from the bench top
`timescale 1ns/1ps
`include "ldiw_defs.svh"

module ldiw_monitor import ldiw_pkg::*; #(
    parameter int DROP_CYCLES = 20,
    parameter int GLITCH_CYCLES = 2
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic scl_pin,
    input wire logic sda_pin,
    input wire logic sda_out,
    input wire logic sda_oe_n,
    input wire logic display_gate_pin,
    input wire logic [`LDIW_DROP_W-1:0] dropout_pin,
    input wire ldiw_dac_t dac_level,
    input wire logic [`LDIW_AUX_COUNT-1:0][7:0] aux_drive,
    input wire ldiw_pump_t pump_mode,
    input wire logic load_pulse
);
    // ==========
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    int quiet_reg;
    int run_reg;
    ldiw_pump_t prev_reg;
    always_ff @(posedge sys_clk) begin
        prev_reg <= pump_mode;
    end
    // forced modes land just after a load, so steps are only judged well clear of one
    always_ff @(posedge sys_clk) begin
        quiet_reg <= (load_pulse || !rst_n) ? 0 : quiet_reg + 1;
    end
    always_ff @(posedge sys_clk) begin
        run_reg <= (|dropout_pin && pump_mode == prev_reg) ? run_reg + 1 : 0;
    end
    sequence s_step;
        quiet_reg > 4 && pump_mode != prev_reg && pump_mode != PUMP_ONE;
    endsequence
    sequence s_ack_low;
        !scl_pin ##1 !sda_oe_n [*4];
    endsequence
    property p_sda_low; !sda_out; endproperty
    a_sda_low: assert property (p_sda_low) else $error("data driven high");
    property p_load_one; load_pulse |=> !load_pulse; endproperty
    a_load_one: assert property (p_load_one) else $error("load too long");
    property p_load_idle; load_pulse |-> scl_pin && sda_pin; endproperty
    a_load_idle: assert property (p_load_idle) else $error("load off stop");
    property p_rst; $rose(rst_n) |-> dac_level == '0 && aux_drive == '0 && pump_mode == PUMP_ONE;
    endproperty
    a_rst: assert property (p_rst) else $error("reset state wrong");
    // a load forces its held mode one edge later, before quiet_reg has caught up
    property p_no_skip;
        quiet_reg > 4 && !load_pulse && pump_mode == PUMP_ONE |=> pump_mode != PUMP_DOUBLE;
    endproperty
    a_no_skip: assert property (p_no_skip) else $error("pump skipped");
    property p_drop_wait; s_step |-> run_reg >= DROP_CYCLES - 2; endproperty
    a_drop_wait: assert property (p_drop_wait) else $error("step too early");
    property p_ack; $fell(sda_oe_n) |-> s_ack_low; endproperty
    a_ack: assert property (p_ack) else $error("ack badly timed");
    property p_gate; !display_gate_pin [*4] |-> dac_level.secondary == 0 ||
        (dac_level.red == 0 && dac_level.green == 0 && dac_level.blue == 0);
    endproperty
    a_gate: assert property (p_gate) else $error("gate ignored");
endmodule : ldiw_monitor

// ---- tb/ldiw_host_model.sv ----
// bus master model: drives the clock line, releases the data line for ones
// assumes a pull-up resolves the data wire in the bench
`timescale 1ns/1ps

module ldiw_host_model (
    output logic scl,
    output logic sda_drv,
    input wire logic sda
);
    // ==========
    initial begin
        scl = 1'h1;
        sda_drv = 1'h1;
    end
    task automatic put_bit(input logic b);
        #100 sda_drv = b;
        #100 scl = 1'h1;
        #200 scl = 1'h0;
    endtask : put_bit
    // first n of address, sub-address, data, then stop; ack bit set when pulled low
    task automatic xfer(input logic [23:0] v, input int n, output logic [2:0] ack);
        ack = 3'h0;
        #100 sda_drv = 1'h0;
        #200 scl = 1'h0;
        for (int k = 0; k < n; k++) begin
            for (int i = 23 - 8 * k; i > 15 - 8 * k; i--) begin
                put_bit(v[i]);
            end
            // long low phases: the target pulls and lets go a few cycles late
            #100 sda_drv = 1'h1;
            #400 scl = 1'h1;
            #190 ack[2 - k] = !sda;
            #10 scl = 1'h0;
            #300;
        end
        #100 sda_drv = 1'h0;
        #100 scl = 1'h1;
        #200 sda_drv = 1'h1;
        #400;
    endtask : xfer
endmodule : ldiw_host_model

// ---- tb/ldiw_top_tb.sv ----
// bench for the led driver write port: host model on the bus, checker bound
// assumes a pull-up on the data line and a short dropout delay of 20 cycles
`timescale 1ns/1ps
`include "ldiw_defs.svh"
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin n_mismatch++; \
    $display("wrong value t=%0t got=%0h exp=%0h", $time, a, b); end end

module ldiw_top_tb import ldiw_pkg::*;;
    // ==========
    logic sys_clk = 1'h0;
    logic rst_n = 1'h0;
    logic flash = 1'h0;
    logic gate = 1'h1;
    logic [`LDIW_DROP_W-1:0] drop = '0;
    logic scl;
    logic sda_drv;
    logic sda_out;
    logic sda_oe_n;
    logic load_pulse;
    ldiw_dac_t dac;
    logic [`LDIW_AUX_COUNT-1:0][7:0] aux;
    ldiw_pump_t pump;
    logic [2:0] ack;
    logic [7:0] src [4] = '{8'h03, 8'h81, 8'h7E, 8'h09};
    logic [7:0] sel [2] = '{8'hE4, 8'h1B};
    int n_mismatch = 0;
    int tests_run = 0;
    int cycles = 0;
    wire sda = sda_drv & (sda_oe_n | sda_out);
    always #25 sys_clk = ~sys_clk;
    ldiw_host_model host (.scl(scl), .sda_drv(sda_drv), .sda(sda));
    ldiw_top #(.DROP_CYCLES(20)) dut (.sys_clk(sys_clk), .rst_n(rst_n), .scl_pin(scl),
        .sda_pin(sda), .sda_out(sda_out), .sda_oe_n(sda_oe_n), .flash_level_pin(flash),
        .display_gate_pin(gate), .dropout_pin(drop), .dac_level(dac), .aux_drive(aux),
        .pump_mode(pump), .load_pulse(load_pulse));
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic wait_clk(input int n);
        repeat (n) @(posedge sys_clk);
        #5;
    endtask : wait_clk
    task automatic wr(input logic [7:0] s, input logic [7:0] d);
        host.xfer({8'h36, s, d}, 3, ack);
        wait_clk(8);
        `CHK(ack, 3'h7)
    endtask : wr
    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            tally_and_finish();
        end
    end
    initial begin
        wait_clk(3);
        rst_n = 1'h1;
        wait_clk(6);
        `CHK(dac, 32'h0)
        `CHK(aux, 32'h0)
        `CHK(pump, PUMP_ONE)
        $display("test reset done");
        wr(8'h01, 8'hA5);
        wr(8'h02, 8'h3C);
        wr(8'hFB, 8'h81);
        wr(8'h04, 8'h7E);
        wr(8'h06, 8'h96);
        wr(8'h08, 8'hFF);
        `CHK(dac, {4'h5, 4'hA, 4'hC, 8'h81, 8'h7E, 4'h6})
        flash = 1'h1;
        wait_clk(4);
        `CHK(dac.camera, 4'h9)
        foreach (sel[j]) begin
            wr(8'h05, sel[j]);
            for (int i = 0; i < 4; i++) `CHK(aux[i], src[sel[j][2 * i +: 2]])
        end
        $display("test registers done");
        gate = 1'h0;
        wait_clk(4);
        `CHK(dac, {12'h0, 8'h81, 8'h7E, 4'h9})
        wr(8'h07, 8'h02);
        `CHK(dac, {4'h5, 4'hA, 4'hC, 8'h81, 8'h00, 4'h9})
        gate = 1'h1;
        wr(8'h07, 8'h04);
        flash = 1'h0;
        wait_clk(4);
        `CHK(dac.camera, 4'h9)
        host.xfer({8'h36, 8'h03, 8'h00}, 2, ack);
        host.xfer({8'h37, 8'h03, 8'h00}, 3, ack);
        wait_clk(8);
        `CHK(ack, 3'h0)
        `CHK(dac.main, 8'h81)
        $display("test framing done");
        drop[4] = 1'h1;
        wait_clk(10);
        `CHK(pump, PUMP_ONE)
        wait_clk(20);
        `CHK(pump, PUMP_ONE_HALF)
        wait_clk(30);
        `CHK(pump, PUMP_DOUBLE)
        drop = '0;
        flash = 1'h1;
        wait_clk(4);
        flash = 1'h0;
        wait_clk(6);
        `CHK(pump, PUMP_ONE)
        drop[4] = 1'h1;
        wait_clk(30);
        drop = '0;
        wr(8'h07, 8'h08);
        `CHK(pump, PUMP_ONE)
        drop[0] = 1'h1;
        wait_clk(60);
        `CHK(pump, PUMP_ONE)
        wr(8'h07, 8'h40);
        `CHK(pump, PUMP_ONE_HALF)
        wr(8'h07, 8'hC0);
        `CHK(pump, PUMP_DOUBLE)
        $display("test pump done");
        tally_and_finish();
    end
endmodule : ldiw_top_tb

bind ldiw_top ldiw_monitor #(.DROP_CYCLES(DROP_CYCLES), .GLITCH_CYCLES(GLITCH_CYCLES)) mon (
    .sys_clk(sys_clk), .rst_n(rst_n), .scl_pin(scl_pin), .sda_pin(sda_pin),
    .sda_out(sda_out), .sda_oe_n(sda_oe_n), .display_gate_pin(display_gate_pin),
    .dropout_pin(dropout_pin), .dac_level(dac_level), .aux_drive(aux_drive),
    .pump_mode(pump_mode), .load_pulse(load_pulse));
